// *** logic/break_req_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser; a change is accepted once stages two and three
// agree, so a single glitch never reaches the sequencer.
module break_req_sync (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic req_in,
    output logic      req_out
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= req_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out <= 1'b0;
        end else if (s2 == s3) begin
            req_out <= s3;
        end
    end
endmodule

// *** logic/cpu_reset_break_exception_unit.sv ***
`timescale 1ns/1ns
// Overview of operation
// [RULE1] Simultaneous exceptions resolve by fixed table priority, highest first.
// [RULE2] Division error, if checking enabled, gives cause 8, general vector, pc.
// [RULE3] Data TLB miss outside handler: cause 12, fast miss vector, page+addr.
// [RULE4] Data TLB miss inside handler: cause 12, general vector, page+addr.
// [RULE5] Load permission fault: cause 14, general vector, page and address.
// [RULE6] Store permission fault: cause 15, general vector, page and address.
// [RULE7] Region violation on data access: cause 16, general vector, address.
// [RULE8] Reset clears the whole status register before the handler runs.
// [RULE9] After reset invalidate reset-vector cache line, then fetch handler.
// [RULE10] Reset leaves interrupts disabled and supervisor mode when protected.
// [RULE11] Register zero always reads zero; other registers undefined at reset.
// [RULE12] Break entered by break instruction or debug module hardware request.
// [RULE13] Break entry first copies full status into break saved status.
// [RULE14] Break entry clears interrupt enable bit in status.
// [RULE15] Break entry writes next instruction address into register 30.
// [RULE16] With MMU or MPU, break entry clears user mode bit.
// [RULE17] With MMU, break entry sets the exception handling bit.
// [RULE18] Break entry finally redirects fetch to fixed break vector.
// [RULE19] Breaks are accepted even while a general exception runs.
// [RULE20] Break return restores status from saved copy, jumps to register 30.
// [RULE21] Debug code may clobber only register 25, restoring all others.
// [RULE22] User mode bit one means user, zero means supervisor.
// [RULE23] Hardware break request is synchronised and taken at a boundary.
module cpu_reset_break_exception_unit
    import exc_unit_pkg::*;
#(
    parameter int          ADDR_W        = 32,
    parameter logic [31:0] RESET_VECTOR  = 32'h0000_0000,
    parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0020,
    parameter logic [31:0] FASTTLB_VECTOR = 32'h0000_0040,
    parameter logic [31:0] BREAK_VECTOR  = 32'h0000_0100,
    parameter bit          HAS_MMU       = 1'b1,
    parameter bit          HAS_MPU       = 1'b0,
    parameter bit          DIV_CHECK     = 1'b1
)(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Instruction boundary and faults reported by the pipeline
    input  wire logic              insn_boundary_in,
    input  wire logic [ADDR_W-1:0] insn_addr_in,
    input  wire logic [ADDR_W-1:0] data_addr_in,
    input  wire logic [19:0]       virtual_page_number_in,
    input  wire logic              div_error_in,
    input  wire logic              tlb_miss_data_in,
    input  wire logic              tlb_perm_read_in,
    input  wire logic              tlb_perm_write_in,
    input  wire logic              mpu_data_viol_in,
    input  wire logic              break_insn_in,
    input  wire logic              break_return_in,
    input  wire logic              hw_break_req_in,
    // Software writes to status and register file
    input  wire logic              status_wr_in,
    input  wire logic [31:0]       status_wdata_in,
    input  wire logic              gpr_wr_in,
    input  wire logic [4:0]        gpr_waddr_in,
    input  wire logic [31:0]       gpr_wdata_in,
    input  wire logic [4:0]        gpr_raddr_in,
    input  wire logic              cache_inval_done_in,
    // Outputs
    output logic [31:0]            gpr_rdata_out,
    output logic [31:0]            status_out,
    output logic [31:0]            break_status_out,
    output logic [31:0]            break_return_addr_out,
    output logic [31:0]            exception_return_address_reg_out,
    output logic [4:0]             cause_out,
    output logic [31:0]            bad_addr_out,
    output logic [19:0]            virtual_page_number_out,
    output logic                   redirect_out,
    output logic [31:0]            redirect_addr_out,
    output logic                   cache_inval_out,
    output logic [31:0]            cache_inval_addr_out,
    output logic                   fetch_enable_out,
    output logic                   exception_taken_out,
    output logic                   break_taken_out
);
`include "exc_unit_defs.svh"

    exc_state_t  state;
    logic        hw_break;
    logic [31:0] status;
    logic [31:0] gpr [1:31];
    logic        take_break;
    logic        take_exc;
    logic [4:0]  next_cause;
    vector_sel_t next_vec;
    logic        next_has_bad;
    logic        next_has_vpn;

    function automatic logic [31:0] vector_addr(input vector_sel_t v);
        case (v)
            VEC_RESET:   vector_addr = RESET_VECTOR;
            VEC_GENERAL: vector_addr = GENERAL_VECTOR;
            VEC_FASTTLB: vector_addr = FASTTLB_VECTOR;
            default:     vector_addr = BREAK_VECTOR;
        endcase
    endfunction

    break_req_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .req_in     (hw_break_req_in),
        .req_out    (hw_break)
    );

    // Hardware break outranks every instruction-related fault, and breaks
    // are taken even while a general handler runs.
    assign take_break = (state == ST_RUN) && insn_boundary_in &&
                        (hw_break || break_insn_in); // [RULE12] [RULE19] [RULE23]

    // Fault priority follows the fixed table order. [RULE1]
    always_comb begin
        take_exc     = 1'b1;
        next_cause   = `CAUSE_DIV_ERR;
        next_vec     = VEC_GENERAL;
        next_has_bad = 1'b0;
        next_has_vpn = 1'b0;
        if (DIV_CHECK && div_error_in) begin
            next_cause = `CAUSE_DIV_ERR; // [RULE2]
        end else if (HAS_MMU && tlb_miss_data_in) begin
            next_cause   = `CAUSE_TLB_MISS;
            next_has_bad = 1'b1;
            next_has_vpn = 1'b1;
            if (status[`ST_EH_BIT]) begin
                next_vec = VEC_GENERAL; // [RULE4]
            end else begin
                next_vec = VEC_FASTTLB; // [RULE3]
            end
        end else if (HAS_MMU && tlb_perm_read_in) begin
            next_cause   = `CAUSE_TLB_RD; // [RULE5]
            next_has_bad = 1'b1;
            next_has_vpn = 1'b1;
        end else if (HAS_MMU && tlb_perm_write_in) begin
            next_cause   = `CAUSE_TLB_WR; // [RULE6]
            next_has_bad = 1'b1;
            next_has_vpn = 1'b1;
        end else if (HAS_MPU && mpu_data_viol_in) begin
            next_cause   = `CAUSE_MPU_DATA; // [RULE7]
            next_has_bad = 1'b1;
        end else begin
            take_exc = 1'b0;
        end
    end

    // Sequencer: reset invalidates one cache line, then the handler runs.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_RESET;
        end else begin
            case (state)
                ST_RESET: state <= ST_INVAL;
                ST_INVAL: begin
                    if (cache_inval_done_in) begin
                        state <= ST_RUN; // [RULE9]
                    end
                end
                ST_RUN:   state <= ST_RUN;
                default:  state <= ST_RUN;
            endcase
        end
    end

    assign cache_inval_out      = (state == ST_INVAL); // [RULE9]
    assign cache_inval_addr_out = RESET_VECTOR;
    assign fetch_enable_out     = (state == ST_RUN);

    // Status register; break entry wins over a software write.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= `STATUS_RESET; // [RULE8] [RULE10] [RULE22]
        end else if (take_break) begin
            status[`ST_PIE_BIT] <= 1'b0; // [RULE14]
            if (HAS_MMU || HAS_MPU) begin
                status[`ST_U_BIT] <= 1'b0; // [RULE16] [RULE22]
            end
            if (HAS_MMU) begin
                status[`ST_EH_BIT] <= 1'b1; // [RULE17]
            end
        end else if (state == ST_RUN && insn_boundary_in && break_return_in) begin
            status <= break_status_out; // [RULE20]
        end else if (state == ST_RUN && insn_boundary_in && take_exc) begin
            status[`ST_PIE_BIT] <= 1'b0;
            if (HAS_MMU || HAS_MPU) begin
                status[`ST_U_BIT] <= 1'b0;
            end
            if (HAS_MMU) begin
                status[`ST_EH_BIT] <= 1'b1;
            end
        end else if (status_wr_in) begin
            status <= status_wdata_in;
        end
    end

    assign status_out = status;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            break_status_out <= 32'h0000_0000;
        end else if (take_break) begin
            break_status_out <= status; // [RULE13]
        end
    end

    // Register file: contents undefined after reset except register zero.
    always_ff @(posedge ref_clk_in) begin
        if (take_break) begin
            gpr[`BRK_RET_REG] <= insn_addr_in + 32'h0000_0004; // [RULE15]
        end else if (gpr_wr_in && gpr_waddr_in != `ZERO_REG) begin
            gpr[gpr_waddr_in] <= gpr_wdata_in;
        end
    end

    always_comb begin
        if (gpr_raddr_in == `ZERO_REG) begin
            gpr_rdata_out = 32'h0000_0000; // [RULE11]
        end else begin
            gpr_rdata_out = gpr[gpr_raddr_in];
        end
    end

    assign break_return_addr_out = gpr[`BRK_RET_REG];

    // Exception record registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_out                        <= 5'h00;
            bad_addr_out                     <= 32'h0000_0000;
            virtual_page_number_out          <= 20'h00000;
            exception_return_address_reg_out <= 32'h0000_0000;
        end else if (!take_break && state == ST_RUN && insn_boundary_in &&
                     !break_return_in && take_exc) begin
            cause_out <= next_cause;
            exception_return_address_reg_out <= insn_addr_in + 32'h0000_0004; // [RULE2]
            if (next_has_bad) begin
                bad_addr_out <= data_addr_in; // [RULE3] [RULE5] [RULE7]
            end
            if (next_has_vpn) begin
                virtual_page_number_out <= virtual_page_number_in;
            end
        end
    end

    // Redirect pulse and target
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            redirect_out        <= 1'b0;
            redirect_addr_out   <= 32'h0000_0000;
            exception_taken_out <= 1'b0;
            break_taken_out     <= 1'b0;
        end else begin
            redirect_out        <= 1'b0;
            exception_taken_out <= 1'b0;
            break_taken_out     <= 1'b0;
            if (state == ST_INVAL && cache_inval_done_in) begin
                redirect_out      <= 1'b1;
                redirect_addr_out <= vector_addr(VEC_RESET); // [RULE9]
            end else if (take_break) begin
                redirect_out      <= 1'b1;
                break_taken_out   <= 1'b1;
                redirect_addr_out <= vector_addr(VEC_BREAK); // [RULE18]
            end else if (state == ST_RUN && insn_boundary_in && break_return_in) begin
                redirect_out      <= 1'b1;
                redirect_addr_out <= gpr[`BRK_RET_REG]; // [RULE20]
            end else if (state == ST_RUN && insn_boundary_in && take_exc) begin
                redirect_out        <= 1'b1;
                exception_taken_out <= 1'b1;
                redirect_addr_out   <= vector_addr(next_vec); // [RULE1]
            end
        end
    end
endmodule

// *** logic/exc_unit_defs.svh ***
`ifndef EXC_UNIT_DEFS_SVH
`define EXC_UNIT_DEFS_SVH

// Status register field positions
`define ST_U_BIT        0
`define ST_PIE_BIT      1
`define ST_EH_BIT       2
`define STATUS_RESET    32'h0000_0000

// Cause codes
`define CAUSE_DIV_ERR   5'h08
`define CAUSE_TLB_MISS  5'h0C
`define CAUSE_TLB_RD    5'h0E
`define CAUSE_TLB_WR    5'h0F
`define CAUSE_MPU_DATA  5'h10

// Break return address and zero register indices
`define BRK_RET_REG     5'h1E
`define ZERO_REG        5'h00

`endif

// *** logic/exc_unit_pkg.sv ***
package exc_unit_pkg;
    typedef enum logic [4:0] {
        ST_RESET  = 5'b00001,
        ST_INVAL  = 5'b00010,
        ST_RUN    = 5'b00100,
        ST_BREAK  = 5'b01000,
        ST_EXC    = 5'b10000
    } exc_state_t;

    typedef enum logic [1:0] {
        VEC_RESET   = 2'h0,
        VEC_GENERAL = 2'h1,
        VEC_FASTTLB = 2'h2,
        VEC_BREAK   = 2'h3
    } vector_sel_t;
endpackage

// *** test/debug_module_model.sv ***
`timescale 1ns/1ns
module debug_module_model (
    input  wire logic       ref_clk_in,
    input  wire logic       go_in,
    input  wire logic [3:0] lag_in,
    input  wire logic       taken_in,
    output logic            req_out
);
    initial req_out = 1'b0;
    // Level request held until the core reports the break; no boundary view
    always @(posedge go_in) begin
        repeat (lag_in) @(posedge ref_clk_in);
        #3 req_out = 1'b1;
        @(posedge ref_clk_in iff taken_in);
        #3 req_out = 1'b0;
    end
endmodule

// *** test/exc_unit_checker.sv ***
`timescale 1ns/1ns
module exc_unit_checker #(
    parameter int          ADDR_W         = 32,
    parameter logic [31:0] RESET_VECTOR   = 32'h0000_0000,
    parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0020,
    parameter logic [31:0] FASTTLB_VECTOR = 32'h0000_0040,
    parameter logic [31:0] BREAK_VECTOR   = 32'h0000_0100
)(
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic              insn_boundary_in,
    input wire logic [ADDR_W-1:0] insn_addr_in,
    input wire logic [ADDR_W-1:0] data_addr_in,
    input wire logic              div_error_in,
    input wire logic              tlb_miss_data_in,
    input wire logic              tlb_perm_read_in,
    input wire logic              tlb_perm_write_in,
    input wire logic              break_insn_in,
    input wire logic              break_return_in,
    input wire logic              hw_break_req_in,
    input wire logic [4:0]        gpr_raddr_in,
    input wire logic [31:0]       gpr_rdata_out,
    input wire logic [31:0]       status_out,
    input wire logic [31:0]       break_status_out,
    input wire logic [31:0]       break_return_addr_out,
    input wire logic [4:0]        cause_out,
    input wire logic [31:0]       bad_addr_out,
    input wire logic              redirect_out,
    input wire logic [31:0]       redirect_addr_out,
    input wire logic              cache_inval_out,
    input wire logic [31:0]       cache_inval_addr_out,
    input wire logic              fetch_enable_out,
    input wire logic              exception_taken_out,
    input wire logic              break_taken_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic [2:0] quiet;
    logic       ev;
    logic       nb;
    // A synchronised debug request may still be in flight; skip those cycles
    assign ev = fetch_enable_out && insn_boundary_in;
    assign nb = ev && !break_insn_in && !break_return_in && quiet == 3'h7;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            quiet <= 3'h0;
        else if (hw_break_req_in)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    chk_brk_entry: assert property (ev && break_insn_in |=>
        break_taken_out && redirect_addr_out == BREAK_VECTOR
        && status_out[2:0] == 3'h4) else $error("break entry wrong");
    chk_brk_saves: assert property (ev && break_insn_in |=>
        break_status_out == $past(status_out)
        && break_return_addr_out == $past(insn_addr_in) + 32'h4)
        else $error("break save wrong");
    chk_brk_in_exc: assert property (ev && break_insn_in && status_out[2]
        |=> break_taken_out && !exception_taken_out)
        else $error("break refused in handler");
    chk_bret_back: assert property (ev && break_return_in && !break_insn_in
        && quiet == 3'h7 |=> redirect_out && status_out == $past(break_status_out)
        && redirect_addr_out == $past(break_return_addr_out))
        else $error("break return wrong");
    chk_tlb_fast: assert property (nb && tlb_miss_data_in && !div_error_in
        && !status_out[2] |=> cause_out == 5'h0C && bad_addr_out ==
        $past(data_addr_in) && redirect_addr_out == FASTTLB_VECTOR)
        else $error("fast miss wrong");
    chk_tlb_double: assert property (nb && tlb_miss_data_in && !div_error_in
        && status_out[2] |=> cause_out == 5'h0C
        && redirect_addr_out == GENERAL_VECTOR) else $error("double miss");
    chk_div_cause: assert property (nb && div_error_in |=>
        exception_taken_out && cause_out == 5'h08
        && redirect_addr_out == GENERAL_VECTOR) else $error("div error");
    chk_perm_codes: assert property (nb && !div_error_in && !tlb_miss_data_in
        && (tlb_perm_read_in || tlb_perm_write_in) |=> cause_out ==
        ($past(tlb_perm_read_in) ? 5'h0E : 5'h0F)) else $error("perm code");
    chk_reset_entry: assert property ($rose(fetch_enable_out) |->
        redirect_out && redirect_addr_out == RESET_VECTOR
        && status_out == 32'h0) else $error("reset entry wrong");
    chk_inval_first: assert property (cache_inval_out |->
        !fetch_enable_out && cache_inval_addr_out == RESET_VECTOR)
        else $error("invalidate wrong");
    chk_zero_reg: assert property (gpr_raddr_in == 5'h00 |->
        gpr_rdata_out == 32'h0) else $error("r0 not zero");
    cov_brk: cover property (break_taken_out);
    cov_miss: cover property (exception_taken_out && cause_out == 5'h0C);
    cov_bret: cover property (ev && break_return_in);
endmodule
bind cpu_reset_break_exception_unit exc_unit_checker #(.ADDR_W(ADDR_W),
    .RESET_VECTOR(RESET_VECTOR), .GENERAL_VECTOR(GENERAL_VECTOR),
    .FASTTLB_VECTOR(FASTTLB_VECTOR), .BREAK_VECTOR(BREAK_VECTOR))
    u_exc_unit_checker (.ref_clk_in, .rst_in, .insn_boundary_in,
    .insn_addr_in, .data_addr_in, .div_error_in, .tlb_miss_data_in,
    .tlb_perm_read_in, .tlb_perm_write_in, .break_insn_in,
    .break_return_in, .hw_break_req_in, .gpr_raddr_in, .gpr_rdata_out,
    .status_out, .break_status_out, .break_return_addr_out, .cause_out,
    .bad_addr_out, .redirect_out, .redirect_addr_out, .cache_inval_out,
    .cache_inval_addr_out, .fetch_enable_out, .exception_taken_out,
    .break_taken_out);

// *** test/test_cpu_reset_break_exception_unit.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
 mismatches++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_cpu_reset_break_exception_unit;
    localparam logic [31:0] RST_V = 32'h0000_1000;
    localparam logic [31:0] GEN_V = 32'h0000_1020;
    localparam logic [31:0] TLB_V = 32'h0000_1040;
    localparam logic [31:0] BRK_V = 32'h0000_1100;
    logic        ref_clk_in = 0, rst_in = 1, insn_boundary_in = 0;
    logic        status_wr_in = 0, gpr_wr_in = 0, cache_inval_done_in = 0;
    logic        go = 0, hw_break_req_in, redirect_out, cache_inval_out;
    logic        fetch_enable_out, exception_taken_out, break_taken_out;
    logic [3:0]  lag = 0;
    logic [6:0]  evs = 0;
    logic [4:0]  gpr_waddr_in = 0, gpr_raddr_in = 0, cause_out, m;
    logic [19:0] virtual_page_number_in = 0, virtual_page_number_out;
    logic [31:0] insn_addr_in = 0, data_addr_in = 0, status_wdata_in = 0;
    logic [31:0] gpr_wdata_in = 0, gpr_rdata_out, status_out, v;
    logic [31:0] break_status_out, break_return_addr_out, bad_addr_out;
    logic [31:0] exception_return_address_reg_out, redirect_addr_out;
    logic [31:0] cache_inval_addr_out, seed = 32'h6C79_4EBC;
    int          mismatches = 0, total_checks = 0, cyc = 0;
    cpu_reset_break_exception_unit #(.RESET_VECTOR(RST_V),
        .GENERAL_VECTOR(GEN_V), .FASTTLB_VECTOR(TLB_V),
        .BREAK_VECTOR(BRK_V)) u_cpu_reset_break_exception_unit (
        .ref_clk_in, .rst_in, .insn_boundary_in, .insn_addr_in,
        .data_addr_in, .virtual_page_number_in, .div_error_in(evs[0]),
        .tlb_miss_data_in(evs[1]), .tlb_perm_read_in(evs[2]),
        .tlb_perm_write_in(evs[3]), .mpu_data_viol_in(evs[4]),
        .break_insn_in(evs[5]), .break_return_in(evs[6]), .hw_break_req_in,
        .status_wr_in, .status_wdata_in, .gpr_wr_in, .gpr_waddr_in,
        .gpr_wdata_in, .gpr_raddr_in, .cache_inval_done_in, .gpr_rdata_out,
        .status_out, .break_status_out, .break_return_addr_out,
        .exception_return_address_reg_out, .cause_out, .bad_addr_out,
        .virtual_page_number_out, .redirect_out, .redirect_addr_out,
        .cache_inval_out, .cache_inval_addr_out, .fetch_enable_out,
        .exception_taken_out, .break_taken_out);
    debug_module_model u_debug_module_model (.ref_clk_in, .go_in(go),
        .lag_in(lag), .taken_in(break_taken_out), .req_out(hw_break_req_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0);
    endfunction
    function automatic logic [4:0] cause_of(input logic [3:0] f);
        casez (f)
            4'b???1: return 5'h08;
            4'b??10: return 5'h0C;
            4'b?100: return 5'h0E;
            default: return 5'h0F;
        endcase
    endfunction
    task automatic step(input int n = 1);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic wr_status(input logic [31:0] w);
        status_wr_in = 1;
        status_wdata_in = w;
        step();
        status_wr_in = 0;
    endtask
    task automatic fire(input logic [6:0] e, input logic b = 1);
        evs = e;
        insn_boundary_in = b;
        step();
        evs = 0;
        insn_boundary_in = 0;
    endtask
    task automatic do_reset();
        rst_in = 1;
        step(20);
        rst_in = 0;
        step();
        `CHK("inval", 1'b1, cache_inval_out)
        `CHK("fetch", 1'b0, fetch_enable_out)
        cache_inval_done_in = 1;
        step();
        cache_inval_done_in = 0;
        `CHK("run", 1'b1, fetch_enable_out)
        `CHK("rstvec", RST_V, redirect_addr_out)
        `CHK("status", 32'h0, status_out)
        gpr_wr_in = 1;
        gpr_wdata_in = seed;
        step();
        gpr_wr_in = 0;
        `CHK("r0", 32'h0, gpr_rdata_out)
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always #10 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        do_reset();
        fire(7'h01, 1'b0);
        `CHK("idle", 1'b0, exception_taken_out)
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            wr_status(seed);
            insn_addr_in = {seed[31:2], 2'b00};
            data_addr_in = ~seed;
            virtual_page_number_in = seed[27:8];
            m = (i == 0) ? 5'h10 : seed[12:8];
            fire({2'b00, m});
            `CHK("taken", |m[3:0], exception_taken_out)
            if (|m[3:0]) begin
                `CHK("cause", cause_of(m[3:0]), cause_out)
                v = (m[1:0] == 2'b10 && !seed[2]) ? TLB_V : GEN_V;
                `CHK("vector", v, redirect_addr_out)
                if (m[0]) begin
                    v = insn_addr_in + 32'h4;
                    `CHK("ea", v, exception_return_address_reg_out)
                end else begin
                    `CHK("bad", ~seed, bad_addr_out)
                    `CHK("page", seed[27:8], virtual_page_number_out)
                end
            end
        end
        v = seed | 32'h7;
        wr_status(v);
        fire(7'h21);
        `CHK("brk", 1'b1, break_taken_out)
        `CHK("exc", 1'b0, exception_taken_out)
        `CHK("bstat", v, break_status_out)
        `CHK("stat", {v[31:3], 3'b100}, status_out)
        `CHK("bvec", BRK_V, redirect_addr_out)
        gpr_raddr_in = 5'h1E;
        step();
        `CHK("r30", insn_addr_in + 32'h4, gpr_rdata_out)
        gpr_wr_in = 1;
        gpr_waddr_in = 5'h19;
        gpr_wdata_in = ~v;
        step();
        gpr_wr_in = 0;
        gpr_waddr_in = 0;
        `CHK("r30keep", insn_addr_in + 32'h4, gpr_rdata_out)
        gpr_raddr_in = 0;
        wr_status(32'h0);
        fire(7'h40);
        `CHK("bret", v, status_out)
        `CHK("back", insn_addr_in + 32'h4, redirect_addr_out)
        for (int k = 0; k < 2; k++) begin
            lag = k ? 4'h9 : 4'h0;
            go = 1;
            insn_boundary_in = 1;
            for (int c = 0; c < 20 && !break_taken_out; c++) step();
            insn_boundary_in = 0;
            go = 0;
            `CHK("hwbrk", 1'b1, break_taken_out)
            `CHK("hwvec", BRK_V, redirect_addr_out)
            step(8);
        end
        do_reset();
        results();
    end
endmodule
